// ### src/sbsr_status_top.sv
// status summary byte with request enable mask and service request
`timescale 1ns/100ps
`include "sbsr_params.svh"

// Functional notes
// - status registers and error queue readable by host
// - summary byte built from lower status registers
// - bit 1: enabled device status events
// - bit 2: error queue holds entries
// - new error entry requests service if enabled
// - bit 3: enabled questionable event present
// - bit 4: response waiting in output queue
// - bit 5: enabled standard event flag present
// - bit 6: any enabled summary bit, requests service
// - bit 7: enabled operation event present
// - request enable mask written and read back
// - device bit 0 sums static errors 1-4
module sbsr_status_top #(
   parameter int ERRQ_DEPTH = `SBSR_ERRQ_DEPTH,
   parameter int ERRQ_WIDTH = `SBSR_ERRQ_WIDTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] dev_cond_in,
   input wire logic [15:0] dev_enable,
   input wire logic dev_event_clear,
   input wire sbsr_pkg::sbsr_evt16_type ques_status,
   input wire sbsr_pkg::sbsr_evt16_type oper_status,
   input wire sbsr_pkg::sbsr_evt8_type std_event,
   input wire logic message_waiting_flag,
   input wire logic err_push,
   input wire logic [ERRQ_WIDTH-1:0] err_push_code,
   input wire logic err_pop,
   input wire sbsr_pkg::sbsr_sre_cmd_type sre_cmd,
   output logic [7:0] status_summary_byte,
   output logic [7:0] request_enable_mask,
   output logic service_request,
   output logic [15:0] dev_condition,
   output logic [15:0] dev_event,
   output logic [ERRQ_WIDTH-1:0] err_code,
   output logic err_full
);

   logic q_not_empty;
   logic q_new_entry;

   // error queue; its flags feed bit 2 and the service request
   sbsr_error_queue #(
      .WIDTH(ERRQ_WIDTH),
      .DEPTH(ERRQ_DEPTH)
   ) u_errq (
      .clk(clk),
      .rst_n(rst_n),
      .push(err_push),
      .push_code(err_push_code),
      .pop(err_pop),
      .pop_code(err_code),
      .not_empty(q_not_empty),
      .full(err_full),
      .new_entry(q_new_entry)
   );

   // ---- device status register ----
   logic [15:0] dev_cond_reg, dev_cond_next;
   logic [15:0] dev_evt_reg, dev_evt_next;

   // bit 0 is forced to the or of the static error field
   always_comb begin
      dev_cond_next = dev_cond_in;
      dev_cond_next[`SBSR_DEV_SUM_BIT] =
         |dev_cond_in[`SBSR_DEV_STATIC_ERROR_FLAGS_HI:`SBSR_DEV_STATIC_ERROR_FLAGS_LO];
      // a rising condition latches; set beats a clear in the same cycle
      dev_evt_next = dev_evt_reg;
      if (dev_event_clear) begin
         dev_evt_next = '0;
      end
      dev_evt_next = dev_evt_next | (dev_cond_next & ~dev_cond_reg);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_cond_reg <= `SBSR_DEV_RESET;
         dev_evt_reg <= `SBSR_DEV_RESET;
      end else begin
         dev_cond_reg <= dev_cond_next;
         dev_evt_reg <= dev_evt_next;
      end
   end

   // ---- request enable mask ----
   logic [7:0] sre_reg, sre_next;

   // host write through the common command; bit 6 is kept as written
   always_comb begin
      sre_next = sre_reg;
      if (sre_cmd.wr) begin
         sre_next = sre_cmd.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sre_reg <= `SBSR_SRE_RESET;
      end else begin
         sre_reg <= sre_next;
      end
   end

   // ---- summary byte and service request ----
   logic [7:0] stb_reg, stb_next;
   logic mss_reg;
   logic srq_reg, srq_next;
   logic [7:0] stb_raw;

   // summary rebuilt from live flags each cycle, no latching here
   always_comb begin
      stb_raw = `SBSR_STB_RESET;
      stb_raw[`SBSR_BIT_DEV] = |(dev_evt_reg & dev_enable);
      stb_raw[`SBSR_BIT_ERRQ] = q_not_empty;
      stb_raw[`SBSR_BIT_QUES] = |(ques_status.evt & ques_status.ena);
      stb_raw[`SBSR_BIT_MSG] = message_waiting_flag;
      stb_raw[`SBSR_BIT_ESB] = |(std_event.evt & std_event.ena);
      stb_raw[`SBSR_BIT_OPER] = |(oper_status.evt & oper_status.ena);
      stb_next = stb_raw;
      // bit 6 looks at every other bit, so it never feeds itself
      stb_next[`SBSR_BIT_MSS] = |(stb_raw & sre_reg & `SBSR_MSS_EXCL);
      // request on a rising summary, and on each new error when enabled;
      // a held summary would otherwise hide later errors from the host
      srq_next = (stb_next[`SBSR_BIT_MSS] && !mss_reg)
         || (q_new_entry && sre_reg[`SBSR_BIT_ERRQ]);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stb_reg <= `SBSR_STB_RESET;
         mss_reg <= 1'b0;
         srq_reg <= 1'b0;
      end else begin
         stb_reg <= stb_next;
         mss_reg <= stb_next[`SBSR_BIT_MSS];
         srq_reg <= srq_next;
      end
   end

   assign status_summary_byte = stb_reg;
   assign request_enable_mask = sre_reg;
   assign service_request = srq_reg;
   assign dev_condition = dev_cond_reg;
   assign dev_event = dev_evt_reg;

   // ---- checks ----
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // helper: mask as it stood when the summary was formed
   logic [7:0] sre_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sre_q <= `SBSR_SRE_RESET;
      end else begin
         sre_q <= sre_reg;
      end
   end

   property p_bit0_zero;
      !stb_reg[`SBSR_BIT_UNUSED];
   endproperty
   a_bit0_zero: assert property (p_bit0_zero)
      else $error("summary bit 0 not zero");

   property p_errq_bit;
      q_not_empty |=> stb_reg[`SBSR_BIT_ERRQ];
   endproperty
   a_errq_bit: assert property (p_errq_bit)
      else $error("bit 2 missing with queued error");

   property p_errq_clear;
      !q_not_empty |=> !stb_reg[`SBSR_BIT_ERRQ];
   endproperty
   a_errq_clear: assert property (p_errq_clear)
      else $error("bit 2 set with empty queue");

   property p_msg_bit;
      stb_reg[`SBSR_BIT_MSG] == $past(message_waiting_flag);
   endproperty
   a_msg_bit: assert property (p_msg_bit)
      else $error("bit 4 does not follow message flag");

   property p_ques_bit;
      stb_reg[`SBSR_BIT_QUES] == $past(|(ques_status.evt & ques_status.ena));
   endproperty
   a_ques_bit: assert property (p_ques_bit)
      else $error("bit 3 wrong");

   property p_esb_bit;
      stb_reg[`SBSR_BIT_ESB] == $past(|(std_event.evt & std_event.ena));
   endproperty
   a_esb_bit: assert property (p_esb_bit)
      else $error("bit 5 wrong");

   property p_oper_bit;
      stb_reg[`SBSR_BIT_OPER] == $past(|(oper_status.evt & oper_status.ena));
   endproperty
   a_oper_bit: assert property (p_oper_bit)
      else $error("bit 7 wrong");

   property p_dev_bit;
      |(dev_evt_reg & dev_enable) |=> stb_reg[`SBSR_BIT_DEV];
   endproperty
   a_dev_bit: assert property (p_dev_bit)
      else $error("bit 1 missing for enabled device event");

   property p_dev_bit_clear;
      !(|(dev_evt_reg & dev_enable)) |=> !stb_reg[`SBSR_BIT_DEV];
   endproperty
   a_dev_bit_clear: assert property (p_dev_bit_clear)
      else $error("bit 1 set without enabled device event");

   property p_dev_follow;
      dev_condition[15:1] == $past(dev_cond_in[15:1]);
   endproperty
   a_dev_follow: assert property (p_dev_follow)
      else $error("device condition does not follow input");

   property p_dev_sticky;
      !dev_event_clear |=> ((dev_event & $past(dev_event)) == $past(dev_event));
   endproperty
   a_dev_sticky: assert property (p_dev_sticky)
      else $error("device event dropped without clear");

   property p_dev_sum;
      dev_condition[`SBSR_DEV_SUM_BIT] ==
         |dev_condition[`SBSR_DEV_STATIC_ERROR_FLAGS_HI:`SBSR_DEV_STATIC_ERROR_FLAGS_LO];
   endproperty
   a_dev_sum: assert property (p_dev_sum)
      else $error("device bit 0 not static error sum");

   property p_mss_bit;
      stb_reg[`SBSR_BIT_MSS] == |(stb_reg & sre_q & `SBSR_MSS_EXCL);
   endproperty
   a_mss_bit: assert property (p_mss_bit)
      else $error("bit 6 does not match enabled summary");

   sequence s_mss_rise;
      !stb_reg[`SBSR_BIT_MSS] ##1 stb_reg[`SBSR_BIT_MSS];
   endsequence

   property p_mss_srq;
      s_mss_rise |-> service_request;
   endproperty
   a_mss_srq: assert property (p_mss_srq)
      else $error("no service request on summary rise");

   sequence s_err_taken;
      err_push && !err_full && request_enable_mask[`SBSR_BIT_ERRQ]
         && !sre_cmd.wr;
   endsequence

   property p_err_srq;
      s_err_taken |-> ##2 service_request;
   endproperty
   a_err_srq: assert property (p_err_srq)
      else $error("new error did not raise service request");

   property p_full_drop;
      err_push && err_full |=> !q_new_entry;
   endproperty
   a_full_drop: assert property (p_full_drop)
      else $error("push into full queue accepted");

   property p_new_entry_held;
      q_new_entry |-> q_not_empty;
   endproperty
   a_new_entry_held: assert property (p_new_entry_held)
      else $error("new entry with empty queue");

   property p_empty_pop;
      err_pop && !q_not_empty |=> err_code == '0;
   endproperty
   a_empty_pop: assert property (p_empty_pop)
      else $error("read of empty queue gave a code");

   // a request needs a fresh summary rise or an enabled new error
   property p_srq_cause;
      service_request |-> $rose(stb_reg[`SBSR_BIT_MSS])
         || ($past(q_new_entry) && $past(request_enable_mask[`SBSR_BIT_ERRQ]));
   endproperty
   a_srq_cause: assert property (p_srq_cause)
      else $error("service request without cause");

   // a write on the next edge may change the mask again
   property p_sre_store;
      sre_cmd.wr |=> request_enable_mask == $past(sre_cmd.data)
         ##1 ($past(sre_cmd.wr) || $stable(request_enable_mask));
   endproperty
   a_sre_store: assert property (p_sre_store)
      else $error("request enable mask not stored");

   property p_dev_latch;
      (dev_event_clear && (dev_cond_next & ~dev_cond_reg) != 16'h0000)
         |=> dev_event != 16'h0000;
   endproperty
   a_dev_latch: assert property (p_dev_latch)
      else $error("device event lost under clear");

endmodule // sbsr_status_top

// ### src/sbsr_params.svh
// bit positions, reset values, masks and sizes of the status summary block
`ifndef SBSR_PARAMS_SVH
`define SBSR_PARAMS_SVH

// bit positions inside the status summary byte
`define SBSR_BIT_UNUSED 0
`define SBSR_BIT_DEV 1
`define SBSR_BIT_ERRQ 2
`define SBSR_BIT_QUES 3
`define SBSR_BIT_MSG 4
`define SBSR_BIT_ESB 5
`define SBSR_BIT_MSS 6
`define SBSR_BIT_OPER 7

// device status register: summary bit and static error field
`define SBSR_DEV_SUM_BIT 0
`define SBSR_DEV_STATIC_ERROR_FLAGS_LO 1
`define SBSR_DEV_STATIC_ERROR_FLAGS_HI 4

// reset values
`define SBSR_STB_RESET 8'h00
`define SBSR_SRE_RESET 8'h00
`define SBSR_DEV_RESET 16'h0000
`define SBSR_ERR_NONE 16'h0000

// mask that drops bit 6 out of the request summary
`define SBSR_MSS_EXCL 8'hBF

// error queue default shape
`define SBSR_ERRQ_DEPTH 8
`define SBSR_ERRQ_WIDTH 16

`endif

// ### src/sbsr_pkg.sv
// types shared by the status summary block
package sbsr_pkg;

   // event register of a lower status register with its enable
   typedef struct packed {
      logic [15:0] evt;
      logic [15:0] ena;
   } sbsr_evt16_type;

   // standard event flags with their mask
   typedef struct packed {
      logic [7:0] evt;
      logic [7:0] ena;
   } sbsr_evt8_type;

   // request enable mask write command
   typedef struct packed {
      logic wr;
      logic [7:0] data;
   } sbsr_sre_cmd_type;

endpackage

// ### src/sbsr_error_queue.sv
// error queue: fifo of error codes with occupancy and new entry pulse
`timescale 1ns/100ps
`include "sbsr_params.svh"

module sbsr_error_queue #(
   parameter int WIDTH = `SBSR_ERRQ_WIDTH,
   parameter int DEPTH = `SBSR_ERRQ_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_code,
   input wire logic pop,
   output logic [WIDTH-1:0] pop_code,
   output logic not_empty,
   output logic full,
   output logic new_entry
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic [AW:0] count_reg, count_next;
   logic [WIDTH-1:0] pop_code_reg, pop_code_next;
   logic new_entry_reg, new_entry_next;
   logic full_reg, full_next;
   logic do_push, do_pop;

   // a push into a full queue is dropped; pop of empty returns no error
   always_comb begin
      do_push = push && !full_reg;
      do_pop = pop && (count_reg != '0);
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next = count_reg;
      pop_code_next = pop_code_reg;
      if (do_push) begin
         wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (do_pop) begin
         rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
         pop_code_next = mem[rd_ptr_reg];
      end else if (pop) begin
         pop_code_next = `SBSR_ERR_NONE;
      end
      if (do_push && !do_pop) begin
         count_next = count_reg + (AW+1)'(1);
      end else if (do_pop && !do_push) begin
         count_next = count_reg - (AW+1)'(1);
      end
      // full is registered so the output leaves a flip-flop
      full_next = (count_next == (AW+1)'(DEPTH));
      new_entry_next = do_push;
   end

   // storage has no reset; only written slots are ever read
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr_reg] <= push_code;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         pop_code_reg <= `SBSR_ERR_NONE;
         new_entry_reg <= 1'b0;
         full_reg <= 1'b0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
         pop_code_reg <= pop_code_next;
         new_entry_reg <= new_entry_next;
         full_reg <= full_next;
      end
   end

   assign pop_code = pop_code_reg;
   assign not_empty = (count_reg != '0);
   assign full = full_reg;
   assign new_entry = new_entry_reg;

endmodule // sbsr_error_queue

// ### verif/sbsr_host_model.sv
// host side model: writes the request enable mask and reads error entries
`timescale 1ns/100ps
module sbsr_host_model (
   input wire logic clk,
   output sbsr_pkg::sbsr_sre_cmd_type sre_cmd,
   output logic err_pop
);
   initial begin
      sre_cmd = '0;
      err_pop = 1'b0;
   end
   // one strobed write; data turns over afterwards so stale bytes cannot pass
   task automatic write_mask(input logic [7:0] d);
      @(posedge clk);
      #1;
      sre_cmd = '{wr: 1'b1, data: d};
      @(posedge clk);
      #1;
      sre_cmd = '{wr: 1'b0, data: ~d};
   endtask
   // one error read, held for a single sampling edge
   task automatic pop_error();
      @(posedge clk);
      #1;
      err_pop = 1'b1;
      @(posedge clk);
      #1;
      err_pop = 1'b0;
   endtask
endmodule // sbsr_host_model

// ### verif/test_status_byte_service_request.sv
// self-checking bench for the status summary block
`timescale 1ns/100ps
module test_status_byte_service_request;
   localparam int DEPTH = 4;
   logic clk;
   logic rst_n;
   logic [15:0] dev_cond_in;
   logic [15:0] dev_enable;
   logic dev_event_clear;
   sbsr_pkg::sbsr_evt16_type ques_status;
   sbsr_pkg::sbsr_evt16_type oper_status;
   sbsr_pkg::sbsr_evt8_type std_event;
   logic message_waiting_flag;
   logic err_push;
   logic [15:0] err_push_code;
   sbsr_pkg::sbsr_sre_cmd_type sre_cmd;
   logic err_pop;
   logic [7:0] status_summary_byte;
   logic [7:0] request_enable_mask;
   logic service_request;
   logic [15:0] dev_condition;
   logic [15:0] dev_event;
   logic [15:0] err_code;
   logic err_full;
   int err_total = 0;
   int checks = 0;
   int sr_count = 0;
   logic [15:0] q_model[$];
   logic [15:0] cond_m;
   logic [15:0] ev_m;
   logic [7:0] mask_m;
   logic [15:0] exp_code;

   sbsr_status_top #(.ERRQ_DEPTH(DEPTH), .ERRQ_WIDTH(16)) sbsr_status_top_i (.clk(clk), .rst_n(rst_n),
      .dev_cond_in(dev_cond_in), .dev_enable(dev_enable), .dev_event_clear(dev_event_clear),
      .ques_status(ques_status), .oper_status(oper_status), .std_event(std_event),
      .message_waiting_flag(message_waiting_flag), .err_push(err_push), .err_push_code(err_push_code),
      .err_pop(err_pop), .sre_cmd(sre_cmd), .status_summary_byte(status_summary_byte),
      .request_enable_mask(request_enable_mask), .service_request(service_request),
      .dev_condition(dev_condition), .dev_event(dev_event), .err_code(err_code), .err_full(err_full));
   sbsr_host_model sbsr_host_model_i (.clk(clk), .sre_cmd(sre_cmd), .err_pop(err_pop));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // counts high cycles, so a pulse stuck high shows as extra requests
   always @(posedge clk) begin
      if (service_request === 1'b1) sr_count <= sr_count + 1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask
   function automatic logic [7:0] model_summary();
      logic [7:0] s;
      s = 8'h00;
      s[1] = |(ev_m & dev_enable);
      s[2] = q_model.size() > 0;
      s[3] = |(ques_status.evt & ques_status.ena);
      s[4] = message_waiting_flag;
      s[5] = |(std_event.evt & std_event.ena);
      s[7] = |(oper_status.evt & oper_status.ena);
      s[6] = |(s & mask_m & 8'hBF);
      return s;
   endfunction
   task automatic compare_all();
      check("summary", {8'h00, model_summary()}, {8'h00, status_summary_byte});
      check("mask", {8'h00, mask_m}, {8'h00, request_enable_mask});
      check("condition", cond_m, dev_condition);
      check("event", ev_m, dev_event);
      check("full", {15'h0000, q_model.size() == DEPTH}, {15'h0000, err_full});
   endtask
   task automatic set_mask(input logic [7:0] m);
      sbsr_host_model_i.write_mask(m);
      mask_m = m;
   endtask
   // the device bit 0 is the or of the static error bits
   task automatic set_cond(input logic [15:0] c, input logic clr);
      logic [15:0] nc;
      nc = {c[15:1], |c[4:1]};
      // a rise on the clearing edge survives the clear
      ev_m = (clr ? 16'h0000 : ev_m) | (nc & ~cond_m);
      cond_m = nc;
      dev_cond_in = c;
      dev_event_clear = clr;
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // hang guard
   initial begin
      tick(20000);
      err_total++;
      give_verdict();
   end

   initial begin
      rst_n = 1'b0;
      {dev_cond_in, dev_enable, dev_event_clear, ques_status, oper_status} = '0;
      {std_event, message_waiting_flag, err_push, err_push_code} = '0;
      {cond_m, ev_m, mask_m} = '0;
      void'($urandom(26));
      tick(8);
      rst_n = 1'b1;
      tick(1);
      compare_all();
      // mask writes one idle edge apart, each read back
      for (int i = 0; i < 6; i++) begin
         set_mask(i == 0 ? 8'hFF : 8'($urandom));
         check("mask readback", {8'h00, mask_m}, {8'h00, request_enable_mask});
      end
      // random level traffic; clears share the edge of a condition change
      for (int i = 0; i < 40; i++) begin
         set_mask(8'($urandom));
         set_cond(16'($urandom) & 16'h019F, 1'($urandom_range(3) == 0));
         dev_enable = 16'($urandom);
         ques_status = $urandom & $urandom;
         oper_status = $urandom & $urandom;
         std_event = 16'($urandom & $urandom);
         message_waiting_flag = 1'($urandom_range(1));
         tick(1);
         dev_event_clear = 1'b0;
         tick(3);
         compare_all();
      end
      // back-to-back pushes run past full; dropped entries raise nothing
      {ques_status, oper_status, std_event, message_waiting_flag, dev_enable} = '0;
      set_mask(8'h04);
      tick(4);
      sr_count = 0;
      err_push = 1'b1;
      for (int i = 0; i <= DEPTH; i++) begin
         err_push_code = 16'($urandom);
         if (q_model.size() < DEPTH) q_model.push_back(err_push_code);
         tick(1);
      end
      err_push = 1'b0;
      err_push_code = ~err_push_code;
      tick(4);
      check("request count", 16'(DEPTH), 16'(sr_count));
      compare_all();
      // drain in order, then one read of the empty queue
      for (int i = 0; i <= DEPTH; i++) begin
         sbsr_host_model_i.pop_error();
         tick(1);
         exp_code = q_model.size() > 0 ? q_model.pop_front() : 16'h0000;
         check("error code", exp_code, err_code);
      end
      tick(3);
      compare_all();
      // a waiting message with its mask bit gives exactly one request
      set_mask(8'h10);
      tick(2);
      sr_count = 0;
      message_waiting_flag = 1'b1;
      tick(10);
      check("request count", 16'h0001, 16'(sr_count));
      compare_all();
      give_verdict();
   end
endmodule // test_status_byte_service_request
